/* File: verilog/tnc_regs.sv */
// host register slice: command, interrupt mask, source ids and receive flags
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: transmitter available reads 0 only while a send is pending, else 1.
// R2: available, fail and no-reply bits together encode transmit outcome.
// R3: each mask bit set passes its status bit onto the interrupt output.
// R4: 8-bit bus ignores command upper byte; 16-bit host writes 00h there.
// R5: command register reads back the last code written.
// R6: code 03h arms a send that starts at next token arrival.
// R7: continuous remote mode resends on every token after first send.
// R8: free format and single shot modes need a send command per packet.
// R9: code 01h cancels pending send at token arrival, then available is 1.
// R10: host waits for available 1 before treating cancellation as done.
// R11: cancellation stops continuous auto sending until a new send.
// R12: code 09h clears the successor id error bit.
// R13: code 0Ah restarts watch timer, clears its error and remote page flags.
// R14: 0Eh clears power-on and excess refusal, 16h reconfig, 1Eh all three.
// R15: capture source id of last own packet and of last packet.
// R16: source id equal to search id sets the match found status.
// R17: pages 16 to 31 work only at 32 byte pages, else read 1.
// R18: free format page flag set on receive, cleared by write 1 or auto clear.
// R19: remote page flag shows receive in period, cleared by 0Ah or check ok.
// R20: receive inhibit going 1 to 0 sets every page flag to 1.
// R21: low flags hold pages 1 to 15, bit 0 reads 0, 15-4 read 1 at 128/256.
// R22: status bits clear on a written 1 or soft reset; 0 leaves them.
// R23: auto clear disable stops last byte read clearing a free page flag.
// R24: undefined command codes only update the read-back value.
// R25: hardware and software reset restore every initial value; soft reset leaves host_rdata, inhibit_prev and the command pulses alone.
module tnc_regs (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        soft_rst,
    input  wire logic [7:0]  host_addr,
    input  wire logic [15:0] host_wdata,
    input  wire logic [1:0]  host_be,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    output logic      [15:0] host_rdata,
    input  wire logic        wide_bus_select,
    input  wire logic [15:0] int_status,
    output logic             irq,
    input  wire logic        token_arrive,
    input  wire logic        tx_done,
    input  wire logic        tx_error,
    input  wire logic        fbe_noreply,
    input  wire logic        tx_source_select,
    input  wire logic        single_shot_remote,
    output logic             start_tx,
    output logic             tx_available,
    output logic             tx_fail_flag,
    output logic             buffer_query_no_reply,
    input  wire logic        pkt_rx_valid,
    input  wire logic        pkt_to_me,
    input  wire logic [4:0]  pkt_src_id,
    output logic             source_match_found,
    output logic             clr_successor_err,
    output logic             restart_watch_timer,
    output logic             clr_watch_timer_error,
    output logic             clr_power_excess,
    output logic             clr_reconfig,
    input  wire logic        global_rx_inhibit,
    input  wire logic        auto_clear_disable,
    input  wire logic [1:0]  page_size,
    input  wire logic [31:0] page_remote,
    input  wire logic [31:0] page_complete,
    input  wire logic [31:0] last_byte_read,
    input  wire logic        warn_ok
);
    logic [15:0] interrupt_enable_mask;
    logic [7:0]  cmd_code;
    logic [4:0]  last_source_id;
    logic [4:0]  own_last_source_id;
    logic [4:0]  search_source_id;
    logic        inhibit_prev;
    logic [31:0] page_flags;

    tnc_tx_if txi ();

    // address decode
    wire [7:0] word_addr = {host_addr[7:1], 1'b0};
    wire       wr_lo = host_wr && host_be[0];
    wire       wr_hi = host_wr && host_be[1];
    wire       hit_status = (word_addr == tnc_pkg::ADDR_STATUS);
    wire       hit_mask = (word_addr == tnc_pkg::ADDR_MASK);
    wire       hit_cmd = (word_addr == tnc_pkg::ADDR_CMD);
    wire       hit_rx_sid = (word_addr == tnc_pkg::ADDR_RX_SID);
    wire       hit_srch = (word_addr == tnc_pkg::ADDR_SRCH_SID);
    wire       hit_hi = (word_addr == tnc_pkg::ADDR_FLAGS_HI);
    wire       hit_lo = (word_addr == tnc_pkg::ADDR_FLAGS_LO);

    // command strobe: only the low byte carries a code
    wire       cmd_wr = hit_cmd && wr_lo; // R4
    wire       cmd_hi_wr = hit_cmd && wr_hi && wide_bus_select;
    wire [7:0] cmd_val = host_wdata[7:0];
    wire       cmd_send = cmd_wr && (cmd_val == tnc_pkg::CMD_SEND); // R6
    wire       cmd_cancel = cmd_wr && (cmd_val == tnc_pkg::CMD_CANCEL); // R9
    wire       cmd_succ = cmd_wr && (cmd_val == tnc_pkg::CMD_CLR_SUCC); // R12
    wire       cmd_watch = cmd_wr && (cmd_val == tnc_pkg::CMD_WATCH); // R13
    wire       cmd_pwr = cmd_wr && (cmd_val == tnc_pkg::CMD_CLR_PWR);
    wire       cmd_rcfg = cmd_wr && (cmd_val == tnc_pkg::CMD_CLR_RCFG);
    wire       cmd_all = cmd_wr && (cmd_val == tnc_pkg::CMD_CLR_ALL);

    // write-one-to-clear of the transmit outcome bits
    wire       clr_fail = hit_status && wr_lo && host_wdata[tnc_pkg::ST_TX_FAIL]; // R22
    wire       clr_noreply = hit_status && wr_lo && host_wdata[tnc_pkg::ST_NO_REPLY]; // R22

    // receive flag write-one-to-clear vector
    wire [15:0] flag_wr_bits = host_wdata & {{8{host_be[1]}}, {8{host_be[0]}}};
    wire [31:0] flag_wr_clear = {hit_hi && host_wr ? flag_wr_bits : 16'h0000,
                                 hit_lo && host_wr ? flag_wr_bits : 16'h0000}; // R18

    wire       inhibit_release = inhibit_prev && !global_rx_inhibit; // R20

    // read views of the flags with page size masking
    wire       size_32 = (page_size == tnc_pkg::PS_32);
    wire       size_big = (page_size == tnc_pkg::PS_128) || (page_size == tnc_pkg::PS_256);
    wire [15:0] flags_hi_view = size_32 ? page_flags[31:16] : 16'hffff; // R17
    wire [15:0] lo_func_mask = size_big ? 16'hfff0 : 16'h0000;
    wire [15:0] flags_lo_view = (page_flags[15:0] | lo_func_mask) & 16'hfffe; // R21

    // effective interrupt status: transmit bits come from this slice
    wire [15:0] eff_status = {int_status[15:3], buffer_query_no_reply, tx_fail_flag, tx_available};
    assign irq = |(eff_status & interrupt_enable_mask); // R3

    wire [15:0] read_mux = hit_mask   ? interrupt_enable_mask :
                           hit_cmd    ? {8'h00, cmd_code} :
                           hit_rx_sid ? {3'h0, own_last_source_id, 3'h0, last_source_id} :
                           hit_srch   ? {11'h000, search_source_id} :
                           hit_hi     ? flags_hi_view :
                           hit_lo     ? flags_lo_view : 16'h0000;

    wire       sid_hit = pkt_rx_valid && (pkt_src_id == search_source_id);

    // transmit sequencer
    assign txi.send_cmd = cmd_send;
    assign txi.cancel_cmd = cmd_cancel;
    assign txi.token_arrive = token_arrive;
    assign txi.tx_done = tx_done;
    assign txi.continuous = tx_source_select && !single_shot_remote; // R7 R8
    assign tx_available = txi.tx_available;
    assign start_tx = txi.start_tx;

    tnc_tx_seq u_tx_seq (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .soft_rst (soft_rst),
        .tx       (txi)
    );

    tnc_page_flags #(
        .NPAGE (tnc_pkg::NPAGE)
    ) u_page_flags (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .soft_rst           (soft_rst),
        .page_remote        (page_remote),
        .page_complete      (page_complete),
        .last_byte_read     (last_byte_read),
        .wr_clear           (flag_wr_clear),
        .auto_clear_disable (auto_clear_disable),
        .watch_clear        (cmd_watch),
        .warn_ok            (warn_ok),
        .inhibit_release    (inhibit_release),
        .flags              (page_flags)
    );

    // mask, command and search id registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            interrupt_enable_mask <= tnc_pkg::MASK_RST;
            cmd_code <= tnc_pkg::CMD_RST;
            search_source_id <= '0;
        end else if (soft_rst) begin
            interrupt_enable_mask <= tnc_pkg::MASK_RST; // R25
            cmd_code <= tnc_pkg::CMD_RST;
            search_source_id <= '0;
        end else begin
            if (hit_mask && wr_lo) interrupt_enable_mask[7:0] <= host_wdata[7:0];
            if (hit_mask && wr_hi) interrupt_enable_mask[15:8] <= host_wdata[15:8];
            if (cmd_wr) cmd_code <= cmd_val; // R5 R24
            if (hit_srch && wr_lo) search_source_id <= host_wdata[4:0];
        end
    end

    // transmit outcome flags, a new event wins over a clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_fail_flag <= 1'b0;
            buffer_query_no_reply <= 1'b0;
        end else if (soft_rst) begin
            tx_fail_flag <= 1'b0; // R22
            buffer_query_no_reply <= 1'b0;
        end else begin
            if (tx_error || fbe_noreply) tx_fail_flag <= 1'b1; // R2
            else if (clr_fail || cmd_send) tx_fail_flag <= 1'b0;
            if (fbe_noreply) buffer_query_no_reply <= 1'b1; // R2
            else if (clr_noreply || cmd_send) buffer_query_no_reply <= 1'b0;
        end
    end

    // source id capture and match
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_source_id <= '0;
            own_last_source_id <= '0;
            source_match_found <= 1'b0;
        end else if (soft_rst) begin
            last_source_id <= '0; // R25
            own_last_source_id <= '0;
            source_match_found <= 1'b0;
        end else begin
            if (pkt_rx_valid) last_source_id <= pkt_src_id; // R15
            if (pkt_rx_valid && pkt_to_me) own_last_source_id <= pkt_src_id; // R15
            source_match_found <= sid_hit; // R16
        end
    end

    // command side effect pulses
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clr_successor_err <= 1'b0;
            restart_watch_timer <= 1'b0;
            clr_watch_timer_error <= 1'b0;
            clr_power_excess <= 1'b0;
            clr_reconfig <= 1'b0;
        end else begin
            clr_successor_err <= cmd_succ; // R12
            restart_watch_timer <= cmd_watch; // R13
            clr_watch_timer_error <= cmd_watch; // R13
            clr_power_excess <= cmd_pwr || cmd_all; // R14
            clr_reconfig <= cmd_rcfg || cmd_all; // R14
        end
    end

    // read data register and inhibit edge tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_rdata <= 16'h0000;
            inhibit_prev <= 1'b0;
        end else begin
            if (host_rd) host_rdata <= read_mux;
            inhibit_prev <= global_rx_inhibit;
        end
    end

    a_irq_gate: assert property ( // R3
        @(posedge clk_sys) disable iff (rst || soft_rst)
        (hit_mask && host_wr && host_be == 2'b11 && (host_wdata & eff_status) == 16'h0000
         && $stable(int_status)) ##1 $stable(int_status) && $stable(eff_status) |-> !irq)
        else $error("interrupt raised with every active status bit masked");

    a_cmd_upper_kept: assert property ( // R4
        @(posedge clk_sys) disable iff (rst || soft_rst)
        ((cmd_hi_wr || (hit_cmd && wr_hi)) && !wr_lo) |=> $stable(cmd_code))
        else $error("command upper byte write changed the command code");

    a_cmd_readback: assert property ( // R5
        @(posedge clk_sys) disable iff (rst || soft_rst)
        (cmd_wr ##1 !cmd_wr ##1 (host_rd && hit_cmd && !cmd_wr)) |=> host_rdata == {8'h00, $past(cmd_val, 3)})
        else $error("command register did not read back the last code");

    a_send_arms: assert property ( // R6
        @(posedge clk_sys) disable iff (rst || soft_rst)
        cmd_send |=> !tx_available)
        else $error("send command did not clear transmitter available");

    a_watch_cmd: assert property ( // R13
        @(posedge clk_sys) disable iff (rst || soft_rst)
        cmd_watch |=> restart_watch_timer && clr_watch_timer_error ##1 !restart_watch_timer)
        else $error("watch timer command pulse wrong");

    a_pwr_clear: assert property ( // R14
        @(posedge clk_sys) disable iff (rst || soft_rst)
        cmd_pwr |=> clr_power_excess && !clr_reconfig)
        else $error("power-on and refusal clear command misdecoded");

    a_sid_capture: assert property ( // R15
        @(posedge clk_sys) disable iff (rst || soft_rst)
        pkt_rx_valid |=> last_source_id == $past(pkt_src_id))
        else $error("received source id not captured");

    a_sid_match: assert property ( // R16
        @(posedge clk_sys) disable iff (rst || soft_rst)
        (pkt_rx_valid && pkt_src_id == search_source_id) |=> source_match_found)
        else $error("matching source id did not raise match found");

    a_high_flags: assert property ( // R17
        @(posedge clk_sys) disable iff (rst || soft_rst)
        (host_rd && hit_hi && !size_32) |=> host_rdata == 16'hffff)
        else $error("upper page flags not all ones outside 32 byte pages");

    a_inhibit_release: assert property ( // R20
        @(posedge clk_sys) disable iff (rst || soft_rst)
        inhibit_release |=> page_flags == tnc_pkg::FLAGS_RST)
        else $error("receive inhibit release did not restore page flags");

    a_fail_combo: assert property ( // R2
        @(posedge clk_sys) disable iff (rst || soft_rst)
        fbe_noreply |=> tx_fail_flag && buffer_query_no_reply)
        else $error("no reply did not set both fail bits");
endmodule
`default_nettype wire

/* File: verilog/tnc_pkg.sv */
// constants and types shared by the command, mask and receive flag slice
package tnc_pkg;
    localparam logic [7:0]  ADDR_STATUS   = 8'h12;
    localparam logic [7:0]  ADDR_MASK     = 8'h14;
    localparam logic [7:0]  ADDR_CMD      = 8'h16;
    localparam logic [7:0]  ADDR_RX_SID   = 8'h18;
    localparam logic [7:0]  ADDR_SRCH_SID = 8'h1a;
    localparam logic [7:0]  ADDR_FLAGS_HI = 8'h1c;
    localparam logic [7:0]  ADDR_FLAGS_LO = 8'h1e;

    localparam logic [7:0]  CMD_CANCEL    = 8'h01;
    localparam logic [7:0]  CMD_SEND      = 8'h03;
    localparam logic [7:0]  CMD_CLR_SUCC  = 8'h09;
    localparam logic [7:0]  CMD_WATCH     = 8'h0a;
    localparam logic [7:0]  CMD_CLR_PWR   = 8'h0e;
    localparam logic [7:0]  CMD_CLR_RCFG  = 8'h16;
    localparam logic [7:0]  CMD_CLR_ALL   = 8'h1e;

    localparam int          ST_TX_AVAIL   = 0;
    localparam int          ST_TX_FAIL    = 1;
    localparam int          ST_NO_REPLY   = 2;
    localparam int          ID_W          = 5;
    localparam int          MY_SID_LSB    = 8;
    localparam int          NPAGE         = 32;
    localparam int          LO_FUNC_LSB   = 4;

    localparam logic [1:0]  PS_256        = 2'h0;
    localparam logic [1:0]  PS_128        = 2'h1;
    localparam logic [1:0]  PS_64         = 2'h2;
    localparam logic [1:0]  PS_32         = 2'h3;

    localparam logic [15:0] MASK_RST      = 16'h0000;
    localparam logic [7:0]  CMD_RST       = 8'h00;
    localparam logic [31:0] FLAGS_RST     = 32'hffff_fffe;

    typedef enum logic [3:0] {
        TNC_TX_IDLE    = 4'b0001,
        TNC_TX_ARMED   = 4'b0010,
        TNC_TX_SENDING = 4'b0100,
        TNC_TX_CANCEL  = 4'b1000
    } tnc_tx_state_t;
endpackage

/* File: verilog/tnc_tx_if.sv */
// handshake between command decode and the transmit sequencer
`timescale 1ns/100ps
`default_nettype none
interface tnc_tx_if;
    logic send_cmd;
    logic cancel_cmd;
    logic token_arrive;
    logic tx_done;
    logic continuous;
    logic tx_available;
    logic start_tx;
    modport ctl (output send_cmd, cancel_cmd, token_arrive, tx_done, continuous,
                 input tx_available, start_tx);
    modport seq (input send_cmd, cancel_cmd, token_arrive, tx_done, continuous,
                 output tx_available, start_tx);
endinterface
`default_nettype wire

/* File: verilog/tnc_tx_seq.sv */
// transmit sequencer: send arming, token wait, cancellation, auto repeat
`timescale 1ns/100ps
`default_nettype none
module tnc_tx_seq (
    input  wire logic    clk_sys,
    input  wire logic    rst,
    input  wire logic    soft_rst,
    tnc_tx_if.seq        tx
);
    tnc_pkg::tnc_tx_state_t state;
    tnc_pkg::tnc_tx_state_t next_state;
    logic                   auto_repeat;
    logic                   next_auto_repeat;
    wire                    in_idle = (state == tnc_pkg::TNC_TX_IDLE);
    wire                    in_armed = (state == tnc_pkg::TNC_TX_ARMED);

    assign tx.tx_available = in_idle || (state == tnc_pkg::TNC_TX_CANCEL && tx.token_arrive); // R1
    assign tx.start_tx = tx.token_arrive && (in_armed || (in_idle && auto_repeat && !tx.send_cmd)); // R6 R7

    always_comb begin
        next_state = state;
        next_auto_repeat = auto_repeat;
        unique case (state)
            tnc_pkg::TNC_TX_IDLE: begin
                if (tx.send_cmd) next_state = tnc_pkg::TNC_TX_ARMED;
                else if (tx.start_tx) next_state = tnc_pkg::TNC_TX_SENDING; // R7
                if (tx.cancel_cmd) next_auto_repeat = 1'b0; // R11
            end
            tnc_pkg::TNC_TX_ARMED: begin
                if (tx.token_arrive) begin
                    next_state = tnc_pkg::TNC_TX_SENDING; // R6
                    next_auto_repeat = tx.continuous && !tx.cancel_cmd; // R7 R11
                end else if (tx.cancel_cmd) next_state = tnc_pkg::TNC_TX_CANCEL; // R9
            end
            tnc_pkg::TNC_TX_SENDING: begin
                if (tx.tx_done) next_state = tx.send_cmd ? tnc_pkg::TNC_TX_ARMED : tnc_pkg::TNC_TX_IDLE; // R1
                if (tx.cancel_cmd) next_auto_repeat = 1'b0; // R11
            end
            tnc_pkg::TNC_TX_CANCEL: begin
                next_auto_repeat = 1'b0; // R11
                if (tx.send_cmd) next_state = tnc_pkg::TNC_TX_ARMED;
                else if (tx.token_arrive) next_state = tnc_pkg::TNC_TX_IDLE; // R9
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= tnc_pkg::TNC_TX_IDLE;
            auto_repeat <= 1'b0;
        end else if (soft_rst) begin
            state <= tnc_pkg::TNC_TX_IDLE; // R25
            auto_repeat <= 1'b0;
        end else begin
            state <= next_state;
            auto_repeat <= next_auto_repeat;
        end
    end

    a_auto_resend: assert property ( // R7
        @(posedge clk_sys) disable iff (rst || soft_rst)
        (in_idle && auto_repeat && tx.token_arrive && !tx.send_cmd) |-> tx.start_tx ##1 !tx.tx_available)
        else $error("continuous remote send did not restart on token");

    a_cancel_done: assert property ( // R9
        @(posedge clk_sys) disable iff (rst || soft_rst)
        (state == tnc_pkg::TNC_TX_CANCEL && tx.token_arrive && !tx.send_cmd)
        |-> tx.tx_available && !tx.start_tx ##1 in_idle)
        else $error("cancelled send was started or did not free the transmitter");
endmodule
`default_nettype wire

/* File: verilog/tnc_page_flags.sv */
// per page receive flags for free format and remote buffer pages
`timescale 1ns/100ps
`default_nettype none
module tnc_page_flags #(
    parameter int NPAGE = tnc_pkg::NPAGE
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             soft_rst,
    input  wire logic [NPAGE-1:0] page_remote,
    input  wire logic [NPAGE-1:0] page_complete,
    input  wire logic [NPAGE-1:0] last_byte_read,
    input  wire logic [NPAGE-1:0] wr_clear,
    input  wire logic             auto_clear_disable,
    input  wire logic             watch_clear,
    input  wire logic             warn_ok,
    input  wire logic             inhibit_release,
    output logic      [NPAGE-1:0] flags
);
    wire [NPAGE-1:0] auto_clr = last_byte_read & {NPAGE{!auto_clear_disable}}; // R23
    wire [NPAGE-1:0] free_clr = ~page_remote & (wr_clear | auto_clr); // R18
    wire [NPAGE-1:0] rem_clr = page_remote & {NPAGE{watch_clear | warn_ok}}; // R19 R13
    wire [NPAGE-1:0] next_flags = inhibit_release ? tnc_pkg::FLAGS_RST
                                  : (((flags & ~(free_clr | rem_clr)) | page_complete) & tnc_pkg::FLAGS_RST); // R20

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) flags <= tnc_pkg::FLAGS_RST;
        else if (soft_rst) flags <= tnc_pkg::FLAGS_RST; // R25
        else flags <= next_flags;
    end
endmodule
`default_nettype wire

/* File: testbench/tnc_core_model.sv */
// network core model: token on request, send completion after a fixed time
`timescale 1ns/100ps
`default_nettype none
module tnc_core_model #(
    parameter int SEND_CYC = 4
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic token_go,
    input  wire logic start_tx,
    output logic      token_arrive,
    output logic      tx_done
);
    int cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            token_arrive <= 1'b0;
            tx_done <= 1'b0;
            cnt <= 0;
        end else begin
            token_arrive <= token_go;
            tx_done <= (cnt == 1);
            cnt <= start_tx ? SEND_CYC : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tnc_regs_tb.sv */
// self-checking bench for the command, mask, source id and page flag slice
`timescale 1ns/100ps
`default_nettype none
module tnc_regs_tb;
    logic        clk_sys = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, wide = 1'b1, token_go = 1'b0;
    logic        sel = 1'b1, once = 1'b0, valid = 1'b0, to_me = 1'b0, inh = 1'b0, acd = 1'b0, srst = 1'b0;
    logic        err = 1'b0, nrep = 1'b0, fail, norep;
    logic        irq, token_arrive, tx_done, start_tx, avail, match, c1, c2, c3, c4, c5;
    logic [1:0]  be = 2'h3, page_size = tnc_pkg::PS_32;
    logic [4:0]  src = 5'h00;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, int_status = 16'h0000;
    logic [31:0] remote = 32'h0, complete = 32'h0;
    logic [7:0]  codes [6] = '{8'h09, 8'h0a, 8'h0e, 8'h16, 8'h1e, 8'h55};
    logic [4:0]  puls [6] = '{5'h10, 5'h0c, 5'h02, 5'h01, 5'h03, 5'h00};
    int          error_cnt = 0, samples_checked = 0, cyc = 0;
    tnc_regs i_tnc_regs (.clk_sys, .rst, .soft_rst(srst), .host_addr(addr), .host_wdata(wdata), .host_be(be),
        .host_wr, .host_rd, .host_rdata(rdata), .wide_bus_select(wide), .int_status, .irq, .token_arrive,
        .tx_done, .tx_error(err), .fbe_noreply(nrep), .tx_source_select(sel), .single_shot_remote(once),
        .start_tx, .tx_available(avail), .tx_fail_flag(fail), .buffer_query_no_reply(norep), .pkt_rx_valid(valid),
        .pkt_to_me(to_me), .pkt_src_id(src), .source_match_found(match), .clr_successor_err(c1),
        .restart_watch_timer(c2), .clr_watch_timer_error(c3), .clr_power_excess(c4), .clr_reconfig(c5),
        .global_rx_inhibit(inh), .auto_clear_disable(acd), .page_size, .page_remote(remote),
        .page_complete(complete), .last_byte_read(32'h0), .warn_ok(1'b0));
    tnc_core_model i_tnc_core_model (.clk_sys, .rst, .token_go, .start_tx, .token_arrive, .tx_done);
    always #5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys) addr <= a;
        wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk_sys) host_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys) addr <= a;
        host_rd <= 1'b1;
        @(posedge clk_sys) host_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata, e);
    endtask
    task automatic tok(input logic e);
        @(posedge clk_sys) token_go <= 1'b1;
        @(posedge clk_sys) token_go <= 1'b0;
        #1 chk("start_tx", {15'h0, start_tx}, {15'h0, e});
    endtask
    task automatic wait_avail();
        repeat (20) if (avail !== 1'b1) @(posedge clk_sys) #1;
        chk("tx_available", {15'h0, avail}, 16'h0001);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd(tnc_pkg::ADDR_MASK, 16'h0000);
        rd(tnc_pkg::ADDR_CMD, 16'h0000);
        rd(tnc_pkg::ADDR_RX_SID, 16'h0000);
        rd(tnc_pkg::ADDR_FLAGS_HI, 16'hffff);
        rd(tnc_pkg::ADDR_FLAGS_LO, 16'hfffe);
        wr(tnc_pkg::ADDR_MASK, 16'h0100);
        @(posedge clk_sys) int_status <= 16'h0100;
        #1 chk("irq", {15'h0, irq}, 16'h0001);
        @(posedge clk_sys) int_status <= 16'h0200;
        #1 chk("irq", {15'h0, irq}, 16'h0000);
        $display("test mask done");
        wr(tnc_pkg::ADDR_CMD, 16'h0003);
        chk("tx_available", {15'h0, avail}, 16'h0000);
        rd(tnc_pkg::ADDR_CMD, 16'h0003);
        tok(1'b1);
        wait_avail();
        tok(1'b1);
        wait_avail();
        wr(tnc_pkg::ADDR_CMD, 16'h0001);
        tok(1'b0);
        wr(tnc_pkg::ADDR_CMD, 16'h0003);
        wr(tnc_pkg::ADDR_CMD, 16'h0001);
        chk("tx_available", {15'h0, avail}, 16'h0000);
        tok(1'b0);
        wait_avail();
        @(posedge clk_sys) err <= 1'b1;
        @(posedge clk_sys) err <= 1'b0;
        #1 chk("fail", {14'h0, fail, norep}, 16'h0002);
        once <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            sel <= m[0];
            wr(tnc_pkg::ADDR_CMD, 16'h0003);
            tok(1'b1);
            wait_avail();
            tok(1'b0);
        end
        @(posedge clk_sys) nrep <= 1'b1;
        @(posedge clk_sys) nrep <= 1'b0;
        #1 chk("fail", {14'h0, fail, norep}, 16'h0003);
        wr(tnc_pkg::ADDR_STATUS, 16'h0004);
        chk("fail", {14'h0, fail, norep}, 16'h0002);
        $display("test send done");
        for (int i = 0; i < 6; i++) begin
            wr(tnc_pkg::ADDR_CMD, {8'h00, codes[i]});
            chk("pulses", {11'h0, c1, c2, c3, c4, c5}, {11'h0, puls[i]});
            rd(tnc_pkg::ADDR_CMD, {8'h00, codes[i]});
        end
        be <= 2'h2;
        wr(tnc_pkg::ADDR_CMD, 16'h0300);
        be <= 2'h3;
        rd(tnc_pkg::ADDR_CMD, 16'h0055);
        $display("test commands done");
        wr(tnc_pkg::ADDR_SRCH_SID, 16'hff06);
        rd(tnc_pkg::ADDR_SRCH_SID, 16'h0006);
        @(posedge clk_sys) valid <= 1'b1;
        to_me <= 1'b1;
        src <= 5'h11;
        @(posedge clk_sys) to_me <= 1'b0;
        src <= 5'h06;
        #1 chk("match", {15'h0, match}, 16'h0000);
        @(posedge clk_sys) valid <= 1'b0;
        #1 chk("match", {15'h0, match}, 16'h0001);
        rd(tnc_pkg::ADDR_RX_SID, 16'h1106);
        $display("test source ids done");
        wr(tnc_pkg::ADDR_FLAGS_LO, 16'h0003);
        rd(tnc_pkg::ADDR_FLAGS_LO, 16'hfffc);
        remote <= 32'h0002_0000;
        wr(tnc_pkg::ADDR_CMD, 16'h000a);
        rd(tnc_pkg::ADDR_FLAGS_HI, 16'hfffd);
        @(posedge clk_sys) complete <= 32'h0002_0002;
        @(posedge clk_sys) complete <= 32'h0;
        rd(tnc_pkg::ADDR_FLAGS_HI, 16'hffff);
        rd(tnc_pkg::ADDR_FLAGS_LO, 16'hfffe);
        page_size <= tnc_pkg::PS_128;
        wr(tnc_pkg::ADDR_FLAGS_LO, 16'hfffe);
        rd(tnc_pkg::ADDR_FLAGS_LO, 16'hfff0);
        wr(tnc_pkg::ADDR_FLAGS_HI, 16'hffff);
        rd(tnc_pkg::ADDR_FLAGS_HI, 16'hffff);
        @(posedge clk_sys) inh <= 1'b1;
        @(posedge clk_sys) inh <= 1'b0;
        page_size <= tnc_pkg::PS_32;
        rd(tnc_pkg::ADDR_FLAGS_LO, 16'hfffe);
        rd(tnc_pkg::ADDR_FLAGS_HI, 16'hffff);
        @(posedge clk_sys) srst <= 1'b1;
        @(posedge clk_sys) srst <= 1'b0;
        rd(tnc_pkg::ADDR_MASK, 16'h0000);
        chk("fail", {14'h0, fail, norep}, 16'h0000);
        $display("test page flags done");
        end_of_test();
    end
endmodule
`default_nettype wire
